// file: include/drg_pkg.sv
// drg_pkg: constants and types shared by the run command gating block.
// assumes: included before drg_sync_if and both core modules.
package drg_pkg;

  // ****************************************************************
  // digital input function codes and option values
  // ****************************************************************
  localparam int        DRG_N_DI          = 8;     // number of inputs
  localparam int        DRG_FN_W          = 8;     // function code width
  localparam logic [7:0] DRG_MK_FUNC_JOG  = 8'h01; // multi-key = jog
  localparam logic [7:0] DRG_FN_FWD       = 8'h01; // forward run
  localparam logic [7:0] DRG_FN_REV       = 8'h02; // reverse run
  localparam logic [7:0] DRG_FN_RUN_EN    = 8'h12; // run enable (18)
  localparam logic [7:0] DRG_FN_3WIRE     = 8'h13; // three wire (19)
  localparam logic [1:0] DRG_STOP_COAST   = 2'h0;  // block output
  localparam logic [1:0] DRG_STOP_QUICK   = 2'h1;  // quick stop
  localparam logic [1:0] DRG_STOP_RESUME  = 2'h2;  // quick stop resume

  // ****************************************************************
  // timing of pushbutton pulses
  // ****************************************************************
  localparam int DRG_CLK_HZ          = 20_000_000;
  localparam int DRG_MIN_PULSE_US    = 1000;       // 1 ms
  localparam int DRG_MIN_PULSE_CYC   =
    (DRG_MIN_PULSE_US * (DRG_CLK_HZ / 1_000_000));

  // ****************************************************************
  // selections toward the output stage
  // ****************************************************************
  typedef enum logic [2:0] {
    DRG_RAMP_NORMAL_ACC,
    DRG_RAMP_NORMAL_DEC,
    DRG_RAMP_JOG,
    DRG_RAMP_FAST_STOP,
    DRG_RAMP_DWELL
  } drg_ramp_t;

  typedef enum logic [2:0] {
    DRG_SRC_NONE,
    DRG_SRC_DWELL,
    DRG_SRC_KEYPAD_JOG,
    DRG_SRC_TERM_JOG,
    DRG_SRC_NORMAL
  } drg_src_t;

  typedef enum logic [1:0] {
    DRG_GATE_OPEN,
    DRG_GATE_STOPPING,
    DRG_GATE_WAIT_CMD
  } drg_gate_t;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [7:0] DRG_RST_MK_FUNC  = 8'h00;
  localparam logic [2:0] DRG_RST_PIN      = 3'h0;

endpackage

// file: include/drg_sync_if.sv
// drg_sync_if: pin levels before and after synchronising.
// assumes: drg_pkg compiled first; one clock domain.
`timescale 1ns/100ps
interface drg_sync_if
  import drg_pkg::*;
  #(parameter int N_DI = DRG_N_DI);
  logic [N_DI-1:0] raw_di;
  logic            raw_fwd_key;
  logic            raw_rev_key;
  logic            raw_multi_key;
  logic [N_DI-1:0] sync_di;
  logic            sync_fwd_key;
  logic            sync_rev_key;
  logic            sync_multi_key;

  modport syncer (
    input  raw_di, raw_fwd_key, raw_rev_key, raw_multi_key,
    output sync_di, sync_fwd_key, sync_rev_key, sync_multi_key
  );
  modport core (
    output raw_di, raw_fwd_key, raw_rev_key, raw_multi_key,
    input  sync_di, sync_fwd_key, sync_rev_key, sync_multi_key
  );
endinterface

// file: core/drg_pin_sync.sv
// drg_pin_sync: two flip-flop synchroniser for all pin inputs.
// assumes: pins are asynchronous to sys_clk.
`timescale 1ns/100ps
module drg_pin_sync
  import drg_pkg::*;
  #(parameter int N_DI = DRG_N_DI)
  (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // pin levels
  drg_sync_if.syncer pins
  );

  localparam int W = N_DI + 3;

  logic [W-1:0] meta_ff;
  logic [W-1:0] stab_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_stab;

  // first stage feeds only the second
  always_comb
  begin
    nxt_meta = {pins.raw_di, pins.raw_fwd_key, pins.raw_rev_key,
                pins.raw_multi_key};
    nxt_stab = meta_ff;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_ff <= '0;
      stab_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      stab_ff <= nxt_stab;
    end
  end

  assign pins.sync_di        = stab_ff[W-1:3];
  assign pins.sync_fwd_key   = stab_ff[2];
  assign pins.sync_rev_key   = stab_ff[1];
  assign pins.sync_multi_key = stab_ff[0];

endmodule // drg_pin_sync

// file: core/drg_run_gate.sv
// drg_run_gate: run command qualification for a motor drive.
// assumes: cfg_* and status inputs come from logic on sys_clk;
// keys and digital inputs are raw pins.
// Contract
// - keypad jog possible only when multi-key function holds value 1
// - multi-key press toggles keypad jog; jog inverts icon, shows keypad source
// - held forward or reverse key runs that way at jog frequency
// - keypad jog stops when neither direction key is held
// - jog ramps use jog accel and jog decel times
// - while running, multi-key function change and key presses are refused
// - dwell over jog over other sources; keypad jog over terminal jog
// - three-wire mode latches momentary forward or reverse pushbuttons
// - forward and reverse together stop the drive
// - in safe mode run commands execute only with run enable on
// - input with function code 18 is the run enable input
// - safe mode switch 1 gates run commands, 0 leaves them ungated
// - run enable loss with quick stop option uses fast stop time
// - removing run command stops with normal decel time
// - coast option blocks output at once when run enable is off
// - quick stop needs a fresh run command after enable returns
// - quick stop resume continues when enable returns with command on
`timescale 1ns/100ps
module drg_run_gate
  import drg_pkg::*;
  #(parameter int N_DI = DRG_N_DI)
  (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  // keypad and terminal pins
  input  wire logic                     forward_key,
  input  wire logic                     reverse_key,
  input  wire logic                     multi_key,
  input  wire logic [N_DI-1:0]          digital_inputs,
  // configuration
  input  wire logic [7:0]               cfg_multi_key_func,
  input  wire logic                     cfg_terminal_fwd_rev_source,
  input  wire logic                     cfg_safe_mode_switch,
  input  wire logic [1:0]               cfg_permit_loss_stop_option,
  input  wire logic [N_DI*DRG_FN_W-1:0] cfg_di_function,
  // status from neighbouring logic
  input  wire logic                     dwell_active,
  input  wire logic                     term_jog_fwd,
  input  wire logic                     term_jog_rev,
  input  wire logic                     drive_running,
  // toward output stage and display
  output      logic                     run_fwd_ff,
  output      logic                     run_rev_ff,
  output      drg_src_t                 src_sel_ff,
  output      drg_ramp_t                ramp_sel_ff,
  output      logic                     output_block_ff,
  output      logic                     keypad_jog_mode_ff,
  output      logic                     keypad_source_indicator_ff,
  output      logic                     icon_inverted_ff,
  output      logic                     multi_key_reject_ff,
  output      drg_gate_t                gate_state_ff
  );

  // ****************************************************************
  // pin synchronising
  // ****************************************************************
  drg_sync_if #(.N_DI(N_DI)) pins ();

  assign pins.raw_di        = digital_inputs;
  assign pins.raw_fwd_key   = forward_key;
  assign pins.raw_rev_key   = reverse_key;
  assign pins.raw_multi_key = multi_key;

  drg_pin_sync #(.N_DI(N_DI)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .pins    (pins.syncer)
  );

  // ****************************************************************
  // digital input function decode
  // ****************************************************************
  logic run_en_in;
  logic run_en_seen;
  logic tw_stop_in;
  logic tw_seen;
  logic term_fwd_in;
  logic term_rev_in;

  always_comb
  begin
    logic [7:0] fn;
    fn          = 8'h00;
    run_en_in   = 1'b0;
    run_en_seen = 1'b0;
    tw_stop_in  = 1'b0;
    tw_seen     = 1'b0;
    term_fwd_in = 1'b0;
    term_rev_in = 1'b0;
    for (int i = 0; i < N_DI; i++)
    begin
      fn = cfg_di_function[i*DRG_FN_W +: DRG_FN_W];
      if (fn == DRG_FN_RUN_EN)
      begin
        run_en_seen = 1'b1;
        run_en_in   = run_en_in | pins.sync_di[i];
      end
      if (fn == DRG_FN_3WIRE)
      begin
        tw_seen    = 1'b1;
        tw_stop_in = tw_stop_in | pins.sync_di[i];
      end
      if (fn == DRG_FN_FWD)
        term_fwd_in = term_fwd_in | pins.sync_di[i];
      if (fn == DRG_FN_REV)
        term_rev_in = term_rev_in | pins.sync_di[i];
    end
  end

  // ****************************************************************
  // three-wire latch and terminal command
  // ****************************************************************
  logic tw_fwd_ff;
  logic tw_rev_ff;
  logic nxt_tw_fwd;
  logic nxt_tw_rev;
  logic tw_mode;
  logic cmd_fwd;
  logic cmd_rev;

  // stop input (closed = run) releases the latch
  always_comb
  begin
    tw_mode    = tw_seen & cfg_terminal_fwd_rev_source;
    nxt_tw_fwd = 1'b0;
    nxt_tw_rev = 1'b0;
    if (tw_mode && tw_stop_in && !(term_fwd_in && term_rev_in))
    begin
      nxt_tw_fwd = term_fwd_in | (tw_fwd_ff & ~term_rev_in);
      nxt_tw_rev = term_rev_in | (tw_rev_ff & ~term_fwd_in);
    end
    if (tw_mode)
    begin
      cmd_fwd = tw_fwd_ff;
      cmd_rev = tw_rev_ff;
    end
    else
    begin
      cmd_fwd = cfg_terminal_fwd_rev_source & term_fwd_in & ~term_rev_in;
      cmd_rev = cfg_terminal_fwd_rev_source & term_rev_in & ~term_fwd_in;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tw_fwd_ff <= 1'b0;
      tw_rev_ff <= 1'b0;
    end
    else
    begin
      tw_fwd_ff <= nxt_tw_fwd;
      tw_rev_ff <= nxt_tw_rev;
    end
  end

  // ****************************************************************
  // multi-key and keypad jog mode
  // ****************************************************************
  logic       mk_prev_ff;
  logic [7:0] mk_func_ff;
  logic       nxt_mk_prev;
  logic [7:0] nxt_mk_func;
  logic       nxt_jog_mode;
  logic       nxt_mk_reject;
  logic       running;
  logic       mk_press;

  always_comb
  begin
    running       = drive_running | run_fwd_ff | run_rev_ff;
    mk_press      = pins.sync_multi_key & ~mk_prev_ff;
    nxt_mk_prev   = pins.sync_multi_key;
    nxt_mk_func   = running ? mk_func_ff : cfg_multi_key_func;
    nxt_jog_mode  = keypad_jog_mode_ff;
    nxt_mk_reject = mk_press & running;
    if (mk_func_ff != DRG_MK_FUNC_JOG)
      nxt_jog_mode = 1'b0;
    else if (mk_press && !running)
      nxt_jog_mode = ~keypad_jog_mode_ff;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mk_prev_ff                 <= 1'b0;
      mk_func_ff                 <= DRG_RST_MK_FUNC;
      keypad_jog_mode_ff         <= 1'b0;
      keypad_source_indicator_ff <= 1'b0;
      icon_inverted_ff           <= 1'b0;
      multi_key_reject_ff        <= 1'b0;
    end
    else
    begin
      mk_prev_ff                 <= nxt_mk_prev;
      mk_func_ff                 <= nxt_mk_func;
      keypad_jog_mode_ff         <= nxt_jog_mode;
      keypad_source_indicator_ff <= nxt_jog_mode;
      icon_inverted_ff           <= nxt_jog_mode;
      multi_key_reject_ff        <= nxt_mk_reject;
    end
  end

  // ****************************************************************
  // source priority and run enable gate
  // ****************************************************************
  drg_src_t  nxt_src;
  drg_gate_t nxt_gate;
  logic      req_fwd;
  logic      req_rev;
  logic      cmd_any;
  logic      gate_on;
  logic      gate_ok;

  // dwell keeps the present direction while it runs
  always_comb
  begin
    nxt_src = DRG_SRC_NONE;
    req_fwd = 1'b0;
    req_rev = 1'b0;
    if (dwell_active)
    begin
      nxt_src = DRG_SRC_DWELL;
      req_fwd = run_fwd_ff;
      req_rev = run_rev_ff;
    end
    else if (keypad_jog_mode_ff)
    begin
      req_fwd = pins.sync_fwd_key & ~pins.sync_rev_key;
      req_rev = pins.sync_rev_key & ~pins.sync_fwd_key;
      nxt_src = (req_fwd | req_rev) ? DRG_SRC_KEYPAD_JOG : DRG_SRC_NONE;
    end
    else if (term_jog_fwd ^ term_jog_rev)
    begin
      nxt_src = DRG_SRC_TERM_JOG;
      req_fwd = term_jog_fwd;
      req_rev = term_jog_rev;
    end
    else if (cmd_fwd ^ cmd_rev)
    begin
      nxt_src = DRG_SRC_NORMAL;
      req_fwd = cmd_fwd;
      req_rev = cmd_rev;
    end
    cmd_any = req_fwd | req_rev;
  end

  // safe mode gate state
  always_comb
  begin
    gate_on  = cfg_safe_mode_switch;
    nxt_gate = gate_state_ff;
    unique case (gate_state_ff)
      DRG_GATE_OPEN:
        if (gate_on && !(run_en_seen && run_en_in))
          nxt_gate = DRG_GATE_STOPPING;
      DRG_GATE_STOPPING:
        if (run_en_in && (cfg_permit_loss_stop_option != DRG_STOP_QUICK))
        begin
          if (cfg_permit_loss_stop_option == DRG_STOP_COAST)
            nxt_gate = DRG_GATE_OPEN;
          else if (cmd_any)
            nxt_gate = DRG_GATE_OPEN;
        end
        else if (cfg_permit_loss_stop_option == DRG_STOP_QUICK &&
                 !running)
          nxt_gate = DRG_GATE_WAIT_CMD;
      DRG_GATE_WAIT_CMD:
        if (run_en_in && !cmd_any)
          nxt_gate = DRG_GATE_OPEN;
    endcase
    if (!gate_on)
      nxt_gate = DRG_GATE_OPEN;
    gate_ok = (nxt_gate == DRG_GATE_OPEN);
  end

  // ****************************************************************
  // run outputs, ramp selection and output block
  // ****************************************************************
  logic      nxt_run_fwd;
  logic      nxt_run_rev;
  logic      nxt_block;
  drg_ramp_t nxt_ramp;
  logic      was_jog;

  always_comb
  begin
    nxt_run_fwd = req_fwd & gate_ok;
    nxt_run_rev = req_rev & gate_ok;
    nxt_block   = (nxt_gate == DRG_GATE_STOPPING) &&
                  (cfg_permit_loss_stop_option == DRG_STOP_COAST);
    was_jog     = (src_sel_ff == DRG_SRC_KEYPAD_JOG) ||
                  (src_sel_ff == DRG_SRC_TERM_JOG);
    if (nxt_src == DRG_SRC_DWELL)
      nxt_ramp = DRG_RAMP_DWELL;
    else if (!gate_ok && nxt_gate != DRG_GATE_OPEN &&
             cfg_permit_loss_stop_option != DRG_STOP_COAST)
      nxt_ramp = DRG_RAMP_FAST_STOP;
    else if (nxt_src == DRG_SRC_KEYPAD_JOG ||
             nxt_src == DRG_SRC_TERM_JOG)
      nxt_ramp = DRG_RAMP_JOG;
    else if (nxt_src == DRG_SRC_NORMAL)
      nxt_ramp = DRG_RAMP_NORMAL_ACC;
    else if (was_jog || (ramp_sel_ff == DRG_RAMP_JOG && running))
      nxt_ramp = DRG_RAMP_JOG;
    else
      nxt_ramp = DRG_RAMP_NORMAL_DEC;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_fwd_ff      <= 1'b0;
      run_rev_ff      <= 1'b0;
      src_sel_ff      <= DRG_SRC_NONE;
      ramp_sel_ff     <= DRG_RAMP_NORMAL_DEC;
      output_block_ff <= 1'b0;
      gate_state_ff   <= DRG_GATE_OPEN;
    end
    else
    begin
      run_fwd_ff      <= nxt_run_fwd;
      run_rev_ff      <= nxt_run_rev;
      src_sel_ff      <= nxt_src;
      ramp_sel_ff     <= nxt_ramp;
      output_block_ff <= nxt_block;
      gate_state_ff   <= nxt_gate;
    end
  end

endmodule // drg_run_gate

// file: tb/drg_run_gate_checker.sv
// drg_run_gate_checker: timing checks on the gating block ports.
// assumes: bound to drg_run_gate; one clock, async active low reset.
`timescale 1ns/100ps
module drg_run_gate_checker
  import drg_pkg::*;
  #(parameter int N_DI = DRG_N_DI)
  (
  // clock and reset
  input wire logic                     sys_clk,
  input wire logic                     arst_n,
  // pins
  input wire logic                     forward_key,
  input wire logic                     reverse_key,
  input wire logic                     multi_key,
  input wire logic [N_DI-1:0]          digital_inputs,
  // configuration and status
  input wire logic [7:0]               cfg_multi_key_func,
  input wire logic                     cfg_terminal_fwd_rev_source,
  input wire logic                     cfg_safe_mode_switch,
  input wire logic [1:0]               cfg_permit_loss_stop_option,
  input wire logic [N_DI*DRG_FN_W-1:0] cfg_di_function,
  input wire logic                     dwell_active,
  input wire logic                     term_jog_fwd,
  input wire logic                     term_jog_rev,
  input wire logic                     drive_running,
  // outputs
  input wire logic                     run_fwd_ff,
  input wire logic                     run_rev_ff,
  input wire drg_src_t                 src_sel_ff,
  input wire drg_ramp_t                ramp_sel_ff,
  input wire logic                     output_block_ff,
  input wire logic                     keypad_jog_mode_ff,
  input wire logic                     keypad_source_indicator_ff,
  input wire logic                     icon_inverted_ff,
  input wire logic                     multi_key_reject_ff,
  input wire drg_gate_t                gate_state_ff
  );
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // key held long enough to pass the syncer and register
  sequence s_fwd_held;
    (keypad_jog_mode_ff && forward_key && !reverse_key && !dwell_active
     && !cfg_safe_mode_switch)[*4];
  endsequence
  sequence s_keys_free;
    (keypad_jog_mode_ff && !forward_key && !reverse_key && !dwell_active
     && !term_jog_fwd && !term_jog_rev)[*4];
  endsequence

  a_jog_fwd_runs: assert property (s_fwd_held |-> run_fwd_ff)
    else $error("keypad jog forward not running");
  a_jog_keys_free: assert property (s_keys_free |-> !run_fwd_ff && !run_rev_ff)
    else $error("keypad jog runs with no key held");
  a_dirs_exclusive: assert property (!(run_fwd_ff && run_rev_ff))
    else $error("both directions commanded");
  a_marks_agree: assert property (keypad_source_indicator_ff ==
    keypad_jog_mode_ff && icon_inverted_ff == keypad_jog_mode_ff)
    else $error("jog display marks disagree with mode");
  a_reject_pulse: assert property (multi_key_reject_ff |=> !multi_key_reject_ff)
    else $error("reject longer than one cycle");
  a_reject_cause: assert property (multi_key_reject_ff |->
    $past(drive_running || run_fwd_ff || run_rev_ff))
    else $error("reject while stopped");
  a_mode_frozen: assert property (drive_running |=> $stable(keypad_jog_mode_ff))
    else $error("jog mode changed while running");
  a_jog_ramp: assert property (run_fwd_ff && src_sel_ff == DRG_SRC_KEYPAD_JOG
    |-> ramp_sel_ff == DRG_RAMP_JOG)
    else $error("keypad jog without jog ramp");
  a_gate_blocks: assert property (cfg_safe_mode_switch &&
    gate_state_ff != DRG_GATE_OPEN |-> !run_fwd_ff && !run_rev_ff)
    else $error("run while safe gate closed");
  a_coast_blocks: assert property (output_block_ff |-> !run_fwd_ff && !run_rev_ff)
    else $error("run while output blocked");
  a_quick_ramp: assert property (gate_state_ff == DRG_GATE_STOPPING &&
    cfg_permit_loss_stop_option == DRG_STOP_QUICK
    |-> ramp_sel_ff == DRG_RAMP_FAST_STOP)
    else $error("quick stop without fast stop ramp");
endmodule // drg_run_gate_checker

bind drg_run_gate drg_run_gate_checker #(.N_DI(N_DI)) u_checker (
  .sys_clk(sys_clk), .arst_n(arst_n), .forward_key(forward_key),
  .reverse_key(reverse_key), .multi_key(multi_key),
  .digital_inputs(digital_inputs), .cfg_multi_key_func(cfg_multi_key_func),
  .cfg_terminal_fwd_rev_source(cfg_terminal_fwd_rev_source),
  .cfg_safe_mode_switch(cfg_safe_mode_switch),
  .cfg_permit_loss_stop_option(cfg_permit_loss_stop_option),
  .cfg_di_function(cfg_di_function), .dwell_active(dwell_active),
  .term_jog_fwd(term_jog_fwd), .term_jog_rev(term_jog_rev),
  .drive_running(drive_running), .run_fwd_ff(run_fwd_ff),
  .run_rev_ff(run_rev_ff), .src_sel_ff(src_sel_ff),
  .ramp_sel_ff(ramp_sel_ff), .output_block_ff(output_block_ff),
  .keypad_jog_mode_ff(keypad_jog_mode_ff),
  .keypad_source_indicator_ff(keypad_source_indicator_ff),
  .icon_inverted_ff(icon_inverted_ff),
  .multi_key_reject_ff(multi_key_reject_ff), .gate_state_ff(gate_state_ff));

// file: tb/drg_operator_model.sv
// drg_operator_model: keypad keys and terminal pushbutton contacts.
// assumes: bench changes req after a falling edge; contacts open low.
`timescale 1ns/100ps
module drg_operator_model
  #(parameter int HOLD = 4)
  (
  // clock
  input  wire logic        sys_clk,
  // requests: 7:0 contacts, 8 forward, 9 reverse, 10 multi-key
  input  wire logic [10:0] req,
  // contact and key levels
  output      logic [10:0] pins
  );
  int hold_cnt [11];

  initial pins = 11'h000;

  // a press stays closed at least HOLD cycles, then opens
  // HOLD is a shortened stand-in for the minimum pulse time; the
  // block does not filter pulses, so run length stays small
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 11; i++)
    begin
      if (req[i])
      begin
        pins[i]     <= 1'b1;
        hold_cnt[i] <= HOLD;
      end
      else if (hold_cnt[i] > 1)
        hold_cnt[i] <= hold_cnt[i] - 1;
      else
        pins[i] <= 1'b0;
    end
  end
endmodule // drg_operator_model

// file: tb/drg_run_gate_bench.sv
// drg_run_gate_bench: self-checking bench for the gating block.
// assumes: drg_pkg, drg_sync_if and core modules compiled first.
`timescale 1ns/100ps
module drg_run_gate_bench import drg_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [10:0] req = 11'h000;
  logic [10:0] pins;
  logic [7:0]  mk_func = 8'h00;
  logic        term_src = 1'b0;
  logic        safe_sw = 1'b0;
  logic [1:0]  stop_opt = 2'h0;
  logic [63:0] di_func = 64'h0;
  logic        dwell = 1'b0;
  logic        tj_fwd = 1'b0;
  logic        tj_rev = 1'b0;
  logic        running = 1'b0;
  logic        run_fwd, run_rev, blk, jog_mode, src_ind, icon, reject;
  drg_src_t    src;
  drg_ramp_t   ramp;
  drg_gate_t   gate;
  int          num_errors = 0;
  int          total_checks = 0;

  // ****************************************************************
  // clock, model and block
  // ****************************************************************
  always #25 sys_clk = ~sys_clk;

  drg_operator_model #(.HOLD(4)) u_model (.sys_clk(sys_clk), .req(req),
    .pins(pins));

  drg_run_gate #(.N_DI(8)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .forward_key(pins[8]), .reverse_key(pins[9]), .multi_key(pins[10]),
    .digital_inputs(pins[7:0]), .cfg_multi_key_func(mk_func),
    .cfg_terminal_fwd_rev_source(term_src),
    .cfg_safe_mode_switch(safe_sw),
    .cfg_permit_loss_stop_option(stop_opt), .cfg_di_function(di_func),
    .dwell_active(dwell), .term_jog_fwd(tj_fwd), .term_jog_rev(tj_rev),
    .drive_running(running), .run_fwd_ff(run_fwd), .run_rev_ff(run_rev),
    .src_sel_ff(src), .ramp_sel_ff(ramp), .output_block_ff(blk),
    .keypad_jog_mode_ff(jog_mode), .keypad_source_indicator_ff(src_ind),
    .icon_inverted_ff(icon), .multi_key_reject_ff(reject),
    .gate_state_ff(gate));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one momentary press, stretched by the model
  task automatic press(input int b);
    req[b] = 1'b1;
    step(1);
    req[b] = 1'b0;
    step(8);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset;
    check(run_fwd | run_rev | blk | jog_mode | reject, 8'h00);
    check(src, DRG_SRC_NONE);
    check(ramp, DRG_RAMP_NORMAL_DEC);
    check(gate, DRG_GATE_OPEN);
    $display("test_reset done");
  endtask

  task automatic test_keypad_jog;
    logic seen;
    seen = 1'b0;
    press(10);
    check(jog_mode, 1'b0);
    mk_func = DRG_MK_FUNC_JOG;
    step(2);
    press(10);
    check({jog_mode, src_ind, icon}, 8'h07);
    tj_rev = 1'b1;
    req[8] = 1'b1;
    step(6);
    check({run_fwd, run_rev}, 8'h02);
    check(src, DRG_SRC_KEYPAD_JOG);
    check(ramp, DRG_RAMP_JOG);
    dwell = 1'b1;
    step(2);
    check(src, DRG_SRC_DWELL);
    dwell = 1'b0;
    tj_rev = 1'b0;
    req[8] = 1'b0;
    req[9] = 1'b1;
    step(8); // released key stays closed 4 more cycles, plus sync
    check({run_fwd, run_rev}, 8'h01);
    req[9] = 1'b0;
    step(8);
    check({run_fwd, run_rev}, 8'h00);
    running = 1'b1;
    mk_func = 8'h00;
    req[10] = 1'b1;
    step(1);
    req[10] = 1'b0;
    repeat (8)
    begin
      step(1);
      seen = seen | reject;
    end
    check(seen, 1'b1);
    check(jog_mode, 1'b1);
    mk_func = DRG_MK_FUNC_JOG;
    step(2);
    running = 1'b0;
    step(2);
    press(10);
    check({jog_mode, src_ind, icon}, 8'h00);
    $display("test_keypad_jog done");
  endtask

  task automatic test_three_wire;
    di_func = {32'h0, DRG_FN_RUN_EN, DRG_FN_3WIRE, DRG_FN_REV, DRG_FN_FWD};
    term_src = 1'b1;
    req[2] = 1'b1;
    step(4);
    press(0);
    check({run_fwd, run_rev}, 8'h02);
    check(src, DRG_SRC_NORMAL);
    req[1:0] = 2'h3;
    step(1);
    req[1:0] = 2'h0;
    step(8);
    check({run_fwd, run_rev}, 8'h00);
    press(1);
    check({run_fwd, run_rev}, 8'h01);
    req[2] = 1'b0;
    step(8); // contact opens 4 cycles late, then sync, latch, run
    check({run_fwd, run_rev}, 8'h00);
    check(ramp, DRG_RAMP_NORMAL_DEC);
    $display("test_three_wire done");
  endtask

  task automatic test_safe_mode(input logic [1:0] opt);
    stop_opt = opt;
    safe_sw = 1'b1;
    req[3:2] = 2'h3;
    step(6);
    press(0);
    check(run_fwd, 1'b1);
    running = 1'b1;
    req[3] = 1'b0;
    step(8);
    check(run_fwd, 1'b0);
    if (opt == DRG_STOP_COAST)
      check(blk, 1'b1);
    else
      check(ramp, DRG_RAMP_FAST_STOP);
    running = 1'b0;
    step(3);
    req[3] = 1'b1;
    step(6);
    check(run_fwd, opt != DRG_STOP_QUICK);
    if (opt == DRG_STOP_QUICK)
    begin
      req[2] = 1'b0;
      step(6);
      req[2] = 1'b1;
      step(4);
      press(0);
      check(run_fwd, 1'b1);
    end
    req[3:2] = 2'h0;
    step(6);
    $display("test_safe_mode done");
  endtask

  task automatic test_no_gating;
    safe_sw = 1'b0;
    req[2] = 1'b1;
    step(4);
    press(0);
    check(run_fwd, 1'b1);
    req[2] = 1'b0;
    step(6);
    $display("test_no_gating done");
  endtask

  // ****************************************************************
  // sequence and watchdog
  // ****************************************************************
  initial
  begin
    step(6);
    arst_n = 1'b1;
    step(2);
    test_reset();
    test_keypad_jog();
    test_three_wire();
    for (int i = 0; i < 3; i++)
      test_safe_mode(i[1:0]);
    test_no_gating();
    finish_test();
  end

  initial
  begin
    #(3000 * 50);
    num_errors++;
    finish_test();
  end
endmodule // drg_run_gate_bench
